/* File: scnt_defines.vh */
// Purpose: constants of the synchronous 4-bit up/down counter block
// Assumes: included by bare name; byte offsets on the AXI4-Lite bus
// Notes:   control bits LDN, GPN, GCN and UP are software copies of the counter pins; SW and STEPM are not
// How it works
// - four count bits are flip-flops that all change at one edge.
// - the count state changes only at the rising edge of aclk.
// - load low at an edge copies the four data bits into the count.
// - count advances only with both gates low and load not asserted.
// - direction high counts up, direction low counts down.
// - the carry gate is fed forward, carry asserts only while it is low.
// - gate low, carry goes low at 15 counting up, at 0 counting down.
// - carry is decoded from the settled count, so it never spikes.
// - control changes take effect only at the next sampling edge.
// - gate changes at any clock level never disturb the held count.
// - at count 0 carry follows direction, at 15 it follows it inverted.
`ifndef SCNT_DEFINES_VH
`define SCNT_DEFINES_VH

`define SCNT_CNT_W        4
`define SCNT_ADDR_W       8

`define SCNT_OFF_CTRL     8'h00
`define SCNT_OFF_DATA     8'h04
`define SCNT_OFF_STEP     8'h08
`define SCNT_OFF_STAT     8'h0C
`define SCNT_OFF_WRAPS    8'h10

`define SCNT_CTRL_SW      0
`define SCNT_CTRL_LDN     1
`define SCNT_CTRL_GPN     2
`define SCNT_CTRL_GCN     3
`define SCNT_CTRL_UP      4
`define SCNT_CTRL_STEPM   5
`define SCNT_CTRL_W       6
`define SCNT_CTRL_RST     6'h1E
`define SCNT_DATA_RST     4'h0
`define SCNT_CNT_RST      4'h0
`define SCNT_PIN_RST      4'hF

`define SCNT_ST_CARRYN    4
`define SCNT_ST_WRAP      5
`define SCNT_ST_LOADED    6
`define SCNT_ST_UP        7
`define SCNT_ST_SW        8

`define SCNT_RESP_OKAY    2'h0
`define SCNT_RESP_SLVERR  2'h2

`endif

/* File: scnt_sync2.v */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to aclk
// Notes:   first stage is read only by the second stage
module scnt_sync2 #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout_r
);
  reg [W-1:0] meta_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= INIT;
      dout_r <= INIT;
    end else begin
      meta_r <= din;
      dout_r <= meta_r;
    end
  end
endmodule // scnt_sync2

/* File: scnt_core.v */
// Purpose: 4-bit synchronous up/down counter with load and ripple carry
// Assumes: all inputs already in the aclk domain
// Notes:   carry is registered alongside the count it decodes
`include "scnt_defines.vh"

module scnt_core #(
  parameter W = `SCNT_CNT_W
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         tick,
  input  wire         load_n,
  input  wire         gate_par_n,
  input  wire         gate_carry_n,
  input  wire         up,
  input  wire [W-1:0] din,
  output reg  [W-1:0] count_r,
  output reg          carry_n_r,
  output reg          wrap_r,
  output reg          load_r
);
  reg [W-1:0] count_nxt;
  reg         wrap_nxt;

  // low when the gated count sits at its terminal value
  function carry_n_of;
    input [W-1:0] c;
    input         u;
    input         gc_n;
    begin
      carry_n_of = ~(~gc_n & ((u & (c == {W{1'b1}})) |
                              (~u & (c == {W{1'b0}}))));
    end
  endfunction

  always @* begin
    count_nxt = count_r;
    wrap_nxt  = 1'b0;
    if (tick && !load_n) begin
      count_nxt = din;
    end else if (tick && !gate_par_n && !gate_carry_n) begin
      if (up) begin
        count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
      end else begin
        count_nxt = count_r - {{(W-1){1'b0}}, 1'b1};
      end
      wrap_nxt = ~carry_n_of(count_r, up, gate_carry_n);
    end
    // otherwise the count holds
  end

  // every bit in one register, one edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_r   <= `SCNT_CNT_RST;
      carry_n_r <= 1'b1;
      wrap_r    <= 1'b0;
      load_r    <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      carry_n_r <= carry_n_of(count_nxt, up, gate_carry_n);
      wrap_r    <= wrap_nxt;
      load_r    <= tick & ~load_n;
    end
  end
endmodule // scnt_core

/* File: scnt_top.v */
// Purpose: AXI4-Lite wrapped 4-bit synchronous up/down counter
// Assumes: pins asynchronous to aclk; one clock, synchronous reset
// Notes:   pin changes reach the counter two cycles after they settle
`include "scnt_defines.vh"

module scnt_top #(
  parameter W      = `SCNT_CNT_W,
  parameter ADDR_W = `SCNT_ADDR_W
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              load_n_pin,
  input  wire              count_gate_parallel_pin,
  input  wire              count_gate_carry_pin,
  input  wire              up_dn_pin,
  input  wire [W-1:0]      data_pin,
  output wire [W-1:0]      count_out,
  output wire              ripple_carry_n
);
  localparam SEL_NONE  = 3'h0;
  localparam SEL_CTRL  = 3'h1;
  localparam SEL_DATA  = 3'h2;
  localparam SEL_STEP  = 3'h3;
  localparam SEL_STAT  = 3'h4;
  localparam SEL_WRAPS = 3'h5;

  // write channel state
  reg                awready_r;
  reg                wready_r;
  reg                aw_full_r;
  reg                w_full_r;
  reg  [ADDR_W-1:0]  awaddr_r;
  reg  [31:0]        wdata_r;
  reg  [3:0]         wstrb_r;
  reg                bvalid_r;
  reg  [1:0]         bresp_r;
  // read channel state
  reg                arready_r;
  reg                rvalid_r;
  reg  [31:0]        rdata_r;
  reg  [1:0]         rresp_r;
  reg  [31:0]        rdata_nxt;
  reg  [1:0]         rresp_nxt;
  // software registers
  reg  [`SCNT_CTRL_W-1:0] ctrl_r;
  reg  [W-1:0]       data_r;
  reg                step_r;
  reg                wrap_seen_r;
  reg                load_seen_r;
  reg  [31:0]        wraps_r;

  wire               aw_take;
  wire               w_take;
  wire               wr_do;
  wire [2:0]         wr_sel;
  wire [2:0]         rd_sel;
  wire               ar_take;
  wire [3:0]         pins_sync;
  wire [W-1:0]       data_sync;
  wire               sw_mode;
  wire               eff_load_n;
  wire               eff_gp_n;
  wire               eff_gc_n;
  wire               eff_up;
  wire [W-1:0]       eff_din;
  wire               tick;
  wire [W-1:0]       count_w;
  wire               carry_n_w;
  wire               wrap_w;
  wire               load_w;

  // maps a byte address onto a register select
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
      case ({a[ADDR_W-1:2], 2'b00})
        `SCNT_OFF_CTRL:  reg_sel = SEL_CTRL;
        `SCNT_OFF_DATA:  reg_sel = SEL_DATA;
        `SCNT_OFF_STEP:  reg_sel = SEL_STEP;
        `SCNT_OFF_STAT:  reg_sel = SEL_STAT;
        `SCNT_OFF_WRAPS: reg_sel = SEL_WRAPS;
        default:         reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // pin inputs cross into aclk through two stages
  scnt_sync2 #(
    .W    (4),
    .INIT (`SCNT_PIN_RST)
  ) u_sync_ctl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({up_dn_pin, count_gate_carry_pin,
               count_gate_parallel_pin, load_n_pin}),
    .dout_r  (pins_sync)
  );

  scnt_sync2 #(
    .W    (W),
    .INIT (`SCNT_DATA_RST)
  ) u_sync_dat (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (data_pin),
    .dout_r  (data_sync)
  );

  // software may take the counter away from its pins
  assign sw_mode    = ctrl_r[`SCNT_CTRL_SW];
  assign eff_load_n = sw_mode ? ctrl_r[`SCNT_CTRL_LDN] : pins_sync[0];
  assign eff_gp_n   = sw_mode ? ctrl_r[`SCNT_CTRL_GPN] : pins_sync[1];
  assign eff_gc_n   = sw_mode ? ctrl_r[`SCNT_CTRL_GCN] : pins_sync[2];
  assign eff_up     = sw_mode ? ctrl_r[`SCNT_CTRL_UP]  : pins_sync[3];
  assign eff_din    = sw_mode ? data_r : data_sync;
  // step mode: the counter acts only on a written step pulse
  assign tick       = ~ctrl_r[`SCNT_CTRL_STEPM] | step_r;

  scnt_core #(
    .W (W)
  ) u_core (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .tick         (tick),
    .load_n       (eff_load_n),
    .gate_par_n   (eff_gp_n),
    .gate_carry_n (eff_gc_n),
    .up           (eff_up),
    .din          (eff_din),
    .count_r      (count_w),
    .carry_n_r    (carry_n_w),
    .wrap_r       (wrap_w),
    .load_r       (load_w)
  );

  // core outputs are flip-flops already
  assign count_out      = count_w;
  assign ripple_carry_n = carry_n_w;

  // ---- write address and data, taken in either order
  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take  = s_axi_wvalid & wready_r;
  assign wr_do   = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_sel  = reg_sel(awaddr_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_full_r <= 1'b0;
      awaddr_r  <= {ADDR_W{1'b0}};
    end else if (aw_take) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      awready_r <= 1'b1;
      aw_full_r <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_full_r <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end else if (w_take) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      wready_r <= 1'b1;
      w_full_r <= 1'b0;
    end
  end

  // response one cycle after both halves are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `SCNT_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_sel == SEL_NONE) ? `SCNT_RESP_SLVERR : `SCNT_RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---- software register writes, byte lane 0 only, except WRAPS, which any write clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `SCNT_CTRL_RST;
    end else if (wr_do && wr_sel == SEL_CTRL && wstrb_r[0]) begin
      ctrl_r <= wdata_r[`SCNT_CTRL_W-1:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= `SCNT_DATA_RST;
    end else if (wr_do && wr_sel == SEL_DATA && wstrb_r[0]) begin
      data_r <= wdata_r[W-1:0];
    end
  end

  // one-cycle step pulse, a clock enable for step mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      step_r <= 1'b0;
    end else begin
      step_r <= wr_do & (wr_sel == SEL_STEP) & wstrb_r[0] & wdata_r[0];
    end
  end

  // sticky status flags, write one to clear, a new event wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      wrap_seen_r <= 1'b0;
      load_seen_r <= 1'b0;
    end else begin
      if (wrap_w) begin
        wrap_seen_r <= 1'b1;
      end else if (wr_do && wr_sel == SEL_STAT && wstrb_r[0] &&
                   wdata_r[`SCNT_ST_WRAP]) begin
        wrap_seen_r <= 1'b0;
      end
      if (load_w) begin
        load_seen_r <= 1'b1;
      end else if (wr_do && wr_sel == SEL_STAT && wstrb_r[0] &&
                   wdata_r[`SCNT_ST_LOADED]) begin
        load_seen_r <= 1'b0;
      end
    end
  end

  // wrap counter, any write clears it; a wrap in that cycle counts one
  always @(posedge aclk) begin
    if (!aresetn) begin
      wraps_r <= 32'h00000000;
    end else if (wr_do && wr_sel == SEL_WRAPS) begin
      wraps_r <= {31'h00000000, wrap_w};
    end else if (wrap_w) begin
      wraps_r <= wraps_r + 32'h00000001;
    end
  end

  // ---- read channel
  assign ar_take = s_axi_arvalid & arready_r;
  assign rd_sel  = reg_sel(s_axi_araddr);

  always @* begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = `SCNT_RESP_OKAY;
    case (rd_sel)
      SEL_CTRL: begin
        rdata_nxt[`SCNT_CTRL_W-1:0] = ctrl_r;
      end
      SEL_DATA: begin
        rdata_nxt[W-1:0] = data_r;
      end
      SEL_STEP: begin
        rdata_nxt = 32'h00000000;
      end
      SEL_STAT: begin
        rdata_nxt[W-1:0]             = count_w;
        rdata_nxt[`SCNT_ST_CARRYN]   = carry_n_w;
        rdata_nxt[`SCNT_ST_WRAP]     = wrap_seen_r;
        rdata_nxt[`SCNT_ST_LOADED]   = load_seen_r;
        rdata_nxt[`SCNT_ST_UP]       = eff_up;
        rdata_nxt[`SCNT_ST_SW]       = sw_mode;
      end
      SEL_WRAPS: begin
        rdata_nxt = wraps_r;
      end
      default: begin
        rresp_nxt = `SCNT_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `SCNT_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end
endmodule // scnt_top

/* File: scnt_top_asserts.sv */
// Purpose: port-level checks of the counter block
// Assumes: pin checks stop at the first CTRL write
// Notes:   a pin acts at the third sample after it is driven
module scnt_top_asserts #(
  parameter W = 4
) (
  input wire         aclk,
  input wire         aresetn,
  input wire [7:0]   s_axi_awaddr,
  input wire         s_axi_awvalid,
  input wire         s_axi_awready,
  input wire         s_axi_wvalid,
  input wire         s_axi_wready,
  input wire         s_axi_bvalid,
  input wire         s_axi_arvalid,
  input wire         s_axi_arready,
  input wire         s_axi_rvalid,
  input wire         s_axi_rready,
  input wire [31:0]  s_axi_rdata,
  input wire         load_n_pin,
  input wire         count_gate_parallel_pin,
  input wire         count_gate_carry_pin,
  input wire         up_dn_pin,
  input wire [W-1:0] data_pin,
  input wire [W-1:0] count_out,
  input wire         ripple_carry_n
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [2:0]   age_r;
  reg  [W+3:0] p1_r;
  reg  [W+3:0] p2_r;
  reg  [W+3:0] p3_r;
  reg          soft_r;
  wire         ok  = (age_r == 3'h4) && !soft_r;
  wire         ld  = !p3_r[W+3];
  wire         cnt = p3_r[W+3] & !p3_r[W+2] & !p3_r[W+1];
  wire         up  = p3_r[W];
  // pins as the core sees them, three samples late
  always @(posedge aclk) begin
    p1_r <= {load_n_pin, count_gate_parallel_pin, count_gate_carry_pin, up_dn_pin, data_pin};
    p2_r <= p1_r;
    p3_r <= p2_r;
    if (!aresetn) age_r <= 3'h0;
    else if (age_r != 3'h4) age_r <= age_r + 3'h1;
    // software control may take the counter away from its pins
    if (!aresetn) soft_r <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == 6'h00) soft_r <= 1'b1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  load_cnt_a: assert property (ok && ld |-> count_out == p3_r[W-1:0])
    else $error("count does not match loaded data");
  count_up_a: assert property (
    ok && cnt && up |-> count_out == $past(count_out) + 4'h1)
    else $error("count did not step up");
  count_dn_a: assert property (
    ok && cnt && !up |-> count_out == $past(count_out) - 4'h1)
    else $error("count did not step down");
  count_hold_a: assert property (
    ok && !ld && !cnt |-> $stable(count_out))
    else $error("count moved while disabled");
  carry_dec_a: assert property (ok |->
    ripple_carry_n == !(!p3_r[W+1] && count_out == (up ? 4'hF : 4'h0)))
    else $error("ripple carry wrong");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property (ok && ld);
  cover property (ok && cnt && up && count_out == 4'h0);
  cover property (ok && !ripple_carry_n);
endmodule // scnt_top_asserts

bind scnt_top scnt_top_asserts #(.W(W)) scnt_top_asserts_i (.*);

/* File: scnt_next_stage.sv */
// Purpose: next cascaded counter stage
// Assumes: shares aclk with the block
// Notes:   counts its nibble up while the carry input is low
module scnt_next_stage (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       carry_in_n,
  output reg  [3:0] hi_r
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge aclk) begin
    if (!aresetn) hi_r <= 4'h0;
    else if (!carry_in_n) hi_r <= hi_r + 4'h1;
  end
endmodule // scnt_next_stage

/* File: tb.sv */
// Purpose: self-checking bench of the counter block
// Assumes: pin mode, free running ticks, until the software scenario
// Notes:   pin vectors are {load_n, gate_p, gate_c, up, data}
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        load_n_pin = 1'h1;
  logic        count_gate_parallel_pin = 1'h1;
  logic        count_gate_carry_pin = 1'h1;
  logic        up_dn_pin = 1'h1;
  logic [3:0]  data_pin = 4'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  count_out, hi;
  wire         ripple_carry_n;
  logic [31:0] d;
  logic [1:0]  r;
  int          fails = 0;
  int          checks = 0;

  always #4 aclk = ~aclk;

  scnt_top scnt_top_i (.*);
  scnt_next_stage scnt_next_stage_i (.aclk(aclk), .aresetn(aresetn),
    .carry_in_n(ripple_carry_n), .hi_r(hi));

  task chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task pins(input [7:0] v);
    @(posedge aclk);
    {load_n_pin, count_gate_parallel_pin, count_gate_carry_pin, up_dn_pin, data_pin} <= v;
  endtask

  task axw(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task axr(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task t_reset;
    chk(count_out, 4'h0);
    chk(ripple_carry_n, 1'h1);
    axr(8'h00);
    chk(d, 32'h1E);
    axr(8'h0C);
    chk(d, 32'h90);
  endtask

  task t_regs;
    axr(8'h14);
    chk(r, 2'h2);
    chk(d, 32'h0);
    axw(8'h20, 32'h1);
    chk(r, 2'h2);
    axw(8'h04, 32'h5);
    chk(r, 2'h0);
    axr(8'h04);
    chk(d, 32'h5);
  endtask

  task t_up_wrap;
    pins(8'h7E);
    step(4);
    chk(count_out, 4'hE);
    pins(8'h9E);
    step(3);
    chk(count_out, 4'hF);
    chk(ripple_carry_n, 1'h0);
    step(1);
    chk(count_out, 4'h0);
    chk(ripple_carry_n, 1'h1);
    chk(hi, 4'h1);
    axr(8'h10);
    chk(d, 32'h1);
  endtask

  task t_down;
    pins(8'h61);
    step(4);
    chk(count_out, 4'h1);
    pins(8'h81);
    step(3);
    chk(count_out, 4'h0);
    chk(ripple_carry_n, 1'h0);
    step(1);
    chk(count_out, 4'hF);
    chk(ripple_carry_n, 1'h1);
  endtask

  task t_hold;
    // {pins, count, carry_n}
    logic [15:0] tbl [0:5] = '{16'h7FF1, 16'hDFF0, 16'hCFF1, 16'hBFF1, 16'h4000, 16'hD001};
    for (int i = 0; i < 6; i++) begin
      pins(tbl[i][15:8]);
      step(4);
      chk(count_out, tbl[i][7:4]);
      chk(ripple_carry_n, tbl[i][0]);
    end
  endtask

  // software mode in step mode, sticky flags and wrap count clear
  task t_soft;
    axw(8'h00, 32'h3D);
    step(4);
    chk(count_out, 4'h0);
    axw(8'h08, 32'h1);
    step(1);
    chk(count_out, 4'h5);
    axr(8'h0C);
    chk(d, 32'h1F5);
    axw(8'h0C, 32'h60);
    axr(8'h0C);
    chk(d, 32'h195);
    axw(8'h00, 32'h33);
    axw(8'h08, 32'h1);
    step(1);
    chk(count_out, 4'h6);
    axw(8'h10, 32'h0);
    axr(8'h10);
    chk(d, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    step(1);
    t_reset;
    t_regs;
    t_up_wrap;
    t_down;
    t_hold;
    t_soft;
    stop_test;
  end

  // the run needs about 130 cycles; the limit is 12500 cycles
  initial begin
    #100000;
    fails++;
    stop_test;
  end
endmodule // tb
